// ### design/icu_pkg.sv
package icu_pkg;

	// request lines 0..70; line 0 never has a source
	localparam int unsigned NUM_LINES    = 71;
	localparam int unsigned LINE_IDX_W   = 7;
	localparam int unsigned CORE_ADDR_W  = 24;

	// byte address of the pending_vector_number register
	localparam logic [CORE_ADDR_W-1:0] PENDING_VECTOR_ADDR = 24'hFFFE00;

	// vector = line number + base; line 0 maps to the base itself
	localparam logic [7:0] VECTOR_BASE  = 8'h10;
	localparam logic [7:0] VECTOR_RESET = 8'h10;

	localparam logic       NMI_EN_RESET   = 1'b0;
	localparam logic       NMI_LOCK_RESET = 1'b0;
	localparam logic [7:0] RDATA_RESET    = 8'h00;

	// field positions in the software write to the nonmaskable control register
	localparam int unsigned NMI_CTRL_EN_BIT   = 0;
	localparam int unsigned NMI_CTRL_LOCK_BIT = 1;

	// processor status word global enable bits, as seen by this block
	typedef struct packed {
		logic e_bit;
		logic i_bit;
	} status_word_t;

	// one software write to external_nonmaskable_control
	typedef struct packed {
		logic       wr;
		logic [1:0] data;
	} nmi_ctrl_write_t;

	// core bus request toward this block
	typedef struct packed {
		logic [CORE_ADDR_W-1:0] addr;
		logic                   rd;
		logic                   wr;
	} core_req_t;

	// core bus answer from this block
	typedef struct packed {
		logic       valid;
		logic [7:0] rdata;
	} core_rsp_t;

	typedef enum logic [2:0] {
		NMI_DISABLED = 3'b001,
		NMI_ARMED    = 3'b010,
		NMI_LOCKED   = 3'b100
	} nmi_arm_state_t;

endpackage

// ### design/line_priority_encoder.sv
`timescale 1ns/10ps
module line_priority_encoder (
	input  wire logic [icu_pkg::NUM_LINES-1:0]  requests,
	output logic                                any_request,
	output logic [icu_pkg::LINE_IDX_W-1:0]      top_line
);

	// highest set index wins; the scan runs upward so later hits overwrite
	function automatic logic [icu_pkg::LINE_IDX_W-1:0] highest_line(
		input logic [icu_pkg::NUM_LINES-1:0] req
	);
		logic [icu_pkg::LINE_IDX_W-1:0] idx;
		idx = '0;
		for (int i = 0; i < icu_pkg::NUM_LINES; i++) begin
			if (req[i]) begin
				idx = icu_pkg::LINE_IDX_W'(i);
			end
		end
		return idx;
	endfunction

	always_comb begin
		any_request = |requests;
		top_line    = highest_line(requests);
	end

endmodule

// ### design/nmi_and_maskable_interrupt_unit.sv
`timescale 1ns/10ps
module nmi_and_maskable_interrupt_unit (
	input  wire logic                                clk,
	input  wire logic                                rst_n,
	input  wire logic                                nmi_pin,
	input  wire logic                                nmi_taken,
	input  wire icu_pkg::nmi_ctrl_write_t            nmi_ctrl_write,
	input  wire icu_pkg::status_word_t               processor_status_word,
	input  wire logic [icu_pkg::NUM_LINES-1:0]       maskable_request_line,
	input  wire logic [icu_pkg::NUM_LINES-1:0]       source_enable_register,
	input  wire icu_pkg::core_req_t                  core_req,
	output icu_pkg::core_rsp_t                       core_rsp,
	output logic                                     nmi_request,
	output logic                                     maskable_request,
	output logic                                     nmi_enabled,
	output logic [7:0]                               pending_vector_number
);

	logic                                 nmi_sync1_reg;
	logic                                 nmi_sync2_reg;
	logic                                 nmi_prev_reg;
	logic                                 nmi_fall;
	icu_pkg::nmi_arm_state_t              arm_reg;
	icu_pkg::nmi_arm_state_t              arm_next;
	logic                                 nmi_pending_reg;
	logic                                 en_write;
	logic                                 lock_write;
	logic [icu_pkg::NUM_LINES-1:0]        pending_lines;
	logic                                 any_pending;
	logic [icu_pkg::LINE_IDX_W-1:0]       top_line;
	logic                                 global_enable;
	logic [7:0]                           vector_reg;
	logic [7:0]                           vector_next;
	logic                                 rsp_valid_reg;
	logic [7:0]                           rsp_data_reg;
	logic                                 rd_hit;

	function automatic logic is_vector_addr(input logic [icu_pkg::CORE_ADDR_W-1:0] a);
		return a == icu_pkg::PENDING_VECTOR_ADDR;
	endfunction

	// ---------------- nonmaskable path ----------------

	// two-flop synchroniser on the raw pin; the pin may move at any time
	// relative to clk, so the first stage can go metastable
	// first stage feeds only the second stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			nmi_sync1_reg <= 1'b1;
			nmi_sync2_reg <= 1'b1;
		end else begin
			nmi_sync1_reg <= nmi_pin;
			nmi_sync2_reg <= nmi_sync1_reg;
		end
	end

	// idle high after reset, so a pin held low at release still gives one falling edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			nmi_prev_reg <= 1'b1;
		end else begin
			nmi_prev_reg <= nmi_sync2_reg;
		end
	end

	assign nmi_fall   = nmi_prev_reg & ~nmi_sync2_reg;
	assign en_write   = nmi_ctrl_write.wr & nmi_ctrl_write.data[icu_pkg::NMI_CTRL_EN_BIT];
	assign lock_write = nmi_ctrl_write.wr & nmi_ctrl_write.data[icu_pkg::NMI_CTRL_LOCK_BIT];

	// enable state machine
	// lock is sticky until reset, so it is checked first in the disabled and armed states
	// plain enable is a one-shot: the taken pulse disarms it again
	// writing zero to either bit never disarms anything
	always_comb begin
		arm_next = arm_reg;
		case (arm_reg)
			icu_pkg::NMI_DISABLED: begin
				if (lock_write) begin
					arm_next = icu_pkg::NMI_LOCKED;
				end else if (en_write) begin
					arm_next = icu_pkg::NMI_ARMED;
				end
			end
			icu_pkg::NMI_ARMED: begin
				// a fresh enable write in the taken cycle keeps it armed
				if (lock_write) begin
					arm_next = icu_pkg::NMI_LOCKED;
				end else if (nmi_taken && !en_write) begin
					arm_next = icu_pkg::NMI_DISABLED;
				end
			end
			icu_pkg::NMI_LOCKED: begin
				arm_next = icu_pkg::NMI_LOCKED;
			end
			default: begin
				arm_next = icu_pkg::NMI_DISABLED;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			arm_reg <= icu_pkg::NMI_DISABLED;
		end else begin
			arm_reg <= arm_next;
		end
	end

	// decoded straight from the state; an illegal code reads as disabled
	always_comb begin
		case (arm_reg)
			icu_pkg::NMI_ARMED: begin
				nmi_enabled = 1'b1;
			end
			icu_pkg::NMI_LOCKED: begin
				nmi_enabled = 1'b1;
			end
			default: begin
				nmi_enabled = 1'b0;
			end
		endcase
	end

	// new edge wins over the taken clear in the same cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			nmi_pending_reg <= 1'b0;
		end else if (nmi_fall && nmi_enabled) begin
			nmi_pending_reg <= 1'b1;
		end else if (nmi_taken) begin
			nmi_pending_reg <= 1'b0;
		end
	end

	assign nmi_request = nmi_pending_reg;

	// ---------------- maskable path ----------------

	// no latching: a line counts only while its source holds it
	always_comb begin
		pending_lines    = maskable_request_line & source_enable_register;
		pending_lines[0] = 1'b0;
	end

	line_priority_encoder u_encoder (
		.requests    (pending_lines),
		.any_request (any_pending),
		.top_line    (top_line)
	);

	assign global_enable = processor_status_word.e_bit & processor_status_word.i_bit;

	// combinational so a withdrawn source drops the request at once
	assign maskable_request = any_pending & global_enable;

	// vector is not gated by the status word bits: software may poll it
	// with interrupts off and still see the top enabled pending line
	always_comb begin
		if (any_pending) begin
			vector_next = icu_pkg::VECTOR_BASE + {1'b0, top_line};
		end else begin
			vector_next = icu_pkg::VECTOR_BASE;
		end
	end

	// tracks pending lines every cycle; bus writes never reach it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			vector_reg <= icu_pkg::VECTOR_RESET;
		end else begin
			vector_reg <= vector_next;
		end
	end

	assign pending_vector_number = vector_reg;

	// ---------------- acknowledge read ----------------

	// only a read at the vector address is answered; any other address,
	// and every write, gives no valid pulse
	// the answer uses the registered vector, one cycle behind the lines,
	// so a source that drops just before the read still yields its own vector
	assign rd_hit = core_req.rd && is_vector_addr(core_req.addr);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rsp_valid_reg <= 1'b0;
		end else begin
			rsp_valid_reg <= rd_hit;
		end
	end

	// data held between reads; writes to the address are dropped
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rsp_data_reg <= icu_pkg::RDATA_RESET;
		end else if (rd_hit) begin
			rsp_data_reg <= vector_reg;
		end
	end

	assign core_rsp.valid = rsp_valid_reg;
	assign core_rsp.rdata = rsp_data_reg;

endmodule

// ### dv/nmi_and_maskable_interrupt_unit_assertions.sv
`timescale 1ns/10ps
module nmi_and_maskable_interrupt_unit_assertions (
	input wire logic                   clk,
	input wire logic                   rst_n,
	input wire logic                   nmi_pin,
	input wire logic                   nmi_taken,
	input wire icu_pkg::nmi_ctrl_write_t nmi_ctrl_write,
	input wire icu_pkg::status_word_t  processor_status_word,
	input wire logic [70:0]            maskable_request_line,
	input wire logic [70:0]            source_enable_register,
	input wire icu_pkg::core_req_t     core_req,
	input wire icu_pkg::core_rsp_t     core_rsp,
	input wire logic                   nmi_request,
	input wire logic                   maskable_request,
	input wire logic                   nmi_enabled,
	input wire logic [7:0]             pending_vector_number
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire logic [70:0] live = maskable_request_line & source_enable_register;
	wire logic        hit  = core_req.rd && core_req.addr == icu_pkg::PENDING_VECTOR_ADDR;
	// synchroniser plus edge detect take three edges
	sequence s_fall;
		$fell(nmi_pin) ##0 (nmi_enabled && !nmi_taken) [*3];
	endsequence
	AST_EDGE: assert property (s_fall |=> nmi_request)
		else $error("nmi edge lost");
	AST_RISE: assert property ($rose(nmi_request) |-> $past(nmi_enabled))
		else $error("nmi raised while disabled");
	AST_LOCK: assert property (nmi_ctrl_write.wr && nmi_ctrl_write.data[1] |=> nmi_enabled [*8])
		else $error("locked enable dropped");
	AST_PLAIN: assert property ($fell(nmi_enabled) |-> $past(nmi_taken))
		else $error("enable dropped without taken");
	AST_MREQ: assert property (maskable_request == (|live[70:1] && processor_status_word.e_bit
		&& processor_status_word.i_bit))
		else $error("maskable request wrong");
	AST_VEC0: assert property (!(|live[70:1]) |=> pending_vector_number == 8'h10)
		else $error("idle vector wrong");
	AST_VEC70: assert property (live[70] |=> pending_vector_number == 8'h56)
		else $error("top vector wrong");
	AST_VALID: assert property (hit |=> core_rsp.valid)
		else $error("ack read unanswered");
	AST_NOVAL: assert property (!hit |=> !core_rsp.valid)
		else $error("spurious answer");
	AST_RDATA: assert property (hit |=> core_rsp.rdata == $past(pending_vector_number))
		else $error("ack data wrong");
endmodule
bind nmi_and_maskable_interrupt_unit nmi_and_maskable_interrupt_unit_assertions chk_i (.*);

// ### dv/core_ack_model.sv
`timescale 1ns/10ps
module core_ack_model (
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic               start,
	input  wire logic [23:0]        addr,
	input  wire logic               wr_op,
	input  wire icu_pkg::core_rsp_t core_rsp,
	output icu_pkg::core_req_t      core_req,
	output logic                    got,
	output logic [7:0]              vec
);
	// strobe stands one cycle; answer is taken the cycle after
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			core_req <= '0;
			got      <= 1'b0;
			vec      <= 8'h00;
		end else begin
			core_req <= start ? '{addr, !wr_op, wr_op} : '0;
			if (start) begin
				got      <= 1'b0;
			end else if (core_rsp.valid) begin
				got <= 1'b1;
				vec <= core_rsp.rdata;
			end
		end
	end
endmodule

// ### dv/nmi_and_maskable_interrupt_unit_tb_top.sv
`timescale 1ns/10ps
module nmi_and_maskable_interrupt_unit_tb_top;
	typedef struct {int a; int b; int d; logic [1:0] psw; logic [7:0] req; logic [7:0] vec;} row_t;
	row_t rows [7] = '{
		'{1, 0, 0, 2'b11, 8'h01, 8'h11},
		'{70, 5, 0, 2'b11, 8'h01, 8'h56},
		'{30, 40, 0, 2'b01, 8'h00, 8'h38},
		'{30, 40, 0, 2'b10, 8'h00, 8'h38},
		'{40, 30, 40, 2'b11, 8'h01, 8'h2E},
		'{40, 0, 40, 2'b11, 8'h00, 8'h10},
		'{0, 0, 0, 2'b11, 8'h00, 8'h10}};
	logic clk, rst_n, nmi_pin, nmi_taken, start, wr_op, got;
	logic nmi_request, maskable_request, nmi_enabled;
	logic [23:0] addr;
	logic [7:0] vec, pending_vector_number;
	logic [70:0] maskable_request_line, source_enable_register;
	icu_pkg::nmi_ctrl_write_t nmi_ctrl_write;
	icu_pkg::status_word_t processor_status_word;
	icu_pkg::core_req_t core_req;
	icu_pkg::core_rsp_t core_rsp;
	int mismatches, n_checks;
	nmi_and_maskable_interrupt_unit dut (.*);
	core_ack_model model (.*);
	initial begin
		clk = 0;
		forever #10 clk = ~clk;
	end
	task automatic cyc(int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic chk(string what, logic [7:0] exp, logic [7:0] seen);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic access(logic [23:0] a, logic w);
		start <= 1;
		addr <= a;
		wr_op <= w;
		cyc(1);
		start <= 0;
		cyc(3);
	endtask
	task automatic nmi_fall;
		nmi_pin <= 0;
		cyc(4);
		nmi_pin <= 1;
		cyc(3);
	endtask
	task automatic pulse(logic [1:0] d, logic t);
		nmi_ctrl_write <= '{!t, d};
		nmi_taken <= t;
		cyc(1);
		nmi_ctrl_write <= '0;
		nmi_taken <= 0;
		cyc(1);
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		cyc(3000);
		mismatches++;
		print_verdict;
	end
	initial begin
		{rst_n, nmi_taken, start, wr_op, addr} = '0;
		{nmi_ctrl_write, processor_status_word} = '0;
		{maskable_request_line, source_enable_register} = '0;
		nmi_pin = 1;
		cyc(20);
		chk("reset vector", 8'h10, pending_vector_number);
		chk("reset enable", 8'h00, {7'h0, nmi_enabled});
		$display("reset test done");
		rst_n <= 1;
		cyc(1);
		foreach (rows[i]) begin
			// sources hold levels for the whole row
			maskable_request_line <= (71'(1) << rows[i].a) | (71'(1) << rows[i].b);
			source_enable_register <= ~(71'(1) << rows[i].d);
			processor_status_word <= rows[i].psw;
			cyc(2);
			chk("maskable_request", rows[i].req, {7'h0, maskable_request});
			chk("vector", rows[i].vec, pending_vector_number);
			access(24'hFFFE00, 0);
			chk("ack read", rows[i].vec, vec);
			$display("row %0d done", i);
		end
		maskable_request_line <= 71'(1) << 70;
		cyc(2);
		access(24'hFFFE00, 1);
		chk("vector after write", 8'h56, pending_vector_number);
		access(24'hFFFE01, 0);
		chk("unmapped answer", 8'h00, {7'h0, got});
		$display("bus test done");
		nmi_fall;
		chk("nmi while disabled", 8'h00, {7'h0, nmi_request});
		pulse(2'b01, 0);
		nmi_fall;
		chk("nmi armed", 8'h01, {7'h0, nmi_request});
		pulse(2'b00, 1);
		chk("enable after taken", 8'h00, {7'h0, nmi_enabled});
		nmi_fall;
		chk("nmi after taken", 8'h00, {7'h0, nmi_request});
		pulse(2'b10, 0);
		pulse(2'b00, 1);
		nmi_fall;
		chk("nmi locked", 8'h01, {7'h0, nmi_request});
		rst_n <= 0;
		cyc(2);
		rst_n <= 1;
		cyc(1);
		chk("lock after reset", 8'h00, {7'h0, nmi_enabled});
		$display("nmi test done");
		print_verdict;
	end
endmodule
